// file: rail_enable_defs.vh
`ifndef RAIL_ENABLE_DEFS_VH
`define RAIL_ENABLE_DEFS_VH

// register offsets
`define POWER_GOOD_MASK_ONE_ADDR   8'h25
`define PIN_SEL_MASK_TWO_ADDR 8'h26
`define EDGE_DELAY_ADDR       8'h27

// register reset values
`define POWER_GOOD_MASK_ONE_RST    8'h00
`define PIN_SEL_MASK_TWO_RST  8'h00
`define EDGE_DELAY_RST        8'h00

// answer to an unmapped read
`define UNMAPPED_READ_DATA    8'h00

// second register field positions
`define MASK_THIRD_LDO_BIT    0
`define MASK_FIRST_SWITCH_BIT 1
`define ENABLE_SOURCE_LSB     2
`define ENABLE_SOURCE_MSB     4
`define THRESHOLD_LSB         5
`define THRESHOLD_MSB         6

// third register field positions
`define RISE_DELAY_LSB        0
`define RISE_DELAY_MSB        2
`define FALL_DELAY_LSB        3
`define FALL_DELAY_MSB        5

// enable source codes
`define SRC_PIN_ONE           3'h0
`define SRC_PIN_TWO           3'h1
`define SRC_PIN_FIVE          3'h2
`define SRC_PIN_FOUR          3'h3
`define SRC_PIN_THREE         3'h4
`define SRC_PIN_THREE_FOUR    3'h5
`define SRC_PIN_SIX           3'h6
`define SRC_ALWAYS_ON         3'h7

// timing: one millisecond at the 125 MHz clock
`define CLOCK_MHZ             125
`define MS_IN_NS              1000000
`define CLOCK_PERIOD_NS       8
`define CYCLES_PER_MS         (`MS_IN_NS / `CLOCK_PERIOD_NS)

`endif

// file: edge_delay_timer.v
`timescale 1ns/1ps
`include "rail_enable_defs.vh"

// filters a level: a change is passed on only after it held for the coded time
module edge_delay_timer #(
  parameter CYCLES_PER_MS = `CYCLES_PER_MS,  // cycles in one millisecond
  parameter COUNT_WIDTH   = 24               // holds 64 ms of cycles
) (
  // clock and reset
  input  wire       clk_in,
  input  wire       sys_rst_in,
  // level to filter and delay codes
  input  wire       level_in,
  input  wire [2:0] rise_code_in,
  input  wire [2:0] fall_code_in,
  // delayed level
  output reg        level_out
);

  reg [COUNT_WIDTH-1:0] elapsed;      // cycles the pending change has held
  reg [COUNT_WIDTH-1:0] next_elapsed;
  reg                   next_level;
  reg [COUNT_WIDTH-1:0] target;       // cycles needed for the pending change
  reg [31:0]            target_wide;  // product before trimming to the counter

  // delay code to milliseconds, shared by both edge directions
  function [6:0] code_to_ms;
    input [2:0] code;
    begin
      case (code)
        3'h0:    code_to_ms = 7'h00;
        3'h1:    code_to_ms = 7'h02;
        3'h2:    code_to_ms = 7'h04;
        3'h3:    code_to_ms = 7'h08;
        3'h4:    code_to_ms = 7'h10;
        3'h5:    code_to_ms = 7'h18;
        3'h6:    code_to_ms = 7'h20;
        default: code_to_ms = 7'h40;
      endcase
    end
  endfunction

  // pick the target for the direction of the pending change
  always @* begin
    if (level_in) begin
      target_wide = code_to_ms(rise_code_in) * CYCLES_PER_MS;
    end else begin
      target_wide = code_to_ms(fall_code_in) * CYCLES_PER_MS;
    end
    // COUNT_WIDTH is sized for 64 ms of cycles, so the cut drops only zeros
    target = target_wide[COUNT_WIDTH-1:0];
  end

  // a bounce back to the current level restarts the wait, so glitches shorter than the coded time never pass
  always @* begin
    next_level   = level_out;
    next_elapsed = {COUNT_WIDTH{1'b0}};
    if (level_in != level_out) begin
      // code zero gives the change on the next edge
      if ((elapsed + {{(COUNT_WIDTH-1){1'b0}}, 1'b1}) >= target) begin
        next_level = level_in;
      end else begin
        next_elapsed = elapsed + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // state registers
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      elapsed   <= {COUNT_WIDTH{1'b0}};
      level_out <= 1'b0;
    end else begin
      elapsed   <= next_elapsed;
      level_out <= next_level;
    end
  end

endmodule

// file: shared_rail_enable_logic.v
`timescale 1ns/1ps
`include "rail_enable_defs.vh"

// Functional notes
// - mask one bits: ldo2, load switch, bucks 6..1
// - mask bit one drops that good signal
// - mask two: bit1 switch rail, bit0 ldo3
// - source field bits 4:2 picks control pin
// - code 111 enables without any pin
// - bits 6:5 select power good threshold
// - rise delay coded in bits 2:0
// - fall delay coded in bits 5:3
module shared_rail_enable_logic #(
  parameter CYCLES_PER_MS = `CYCLES_PER_MS  // shorten for simulation
) (
  // clock and reset
  input  wire       clk_in,
  input  wire       sys_rst_in,
  // register port behind the serial front end
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  // control pins, asynchronous
  input  wire       control_pin_one_in,
  input  wire       control_pin_two_in,
  input  wire       control_pin_three_in,
  input  wire       control_pin_four_in,
  input  wire       control_pin_five_in,
  input  wire       control_pin_six_in,
  // power good of other rails, asynchronous, active high
  input  wire       second_general_ldo_power_good_in,
  input  wire       first_load_switch_power_good_in,
  input  wire [5:0] buck_power_good_in,
  input  wire       first_switch_rail_power_good_in,
  input  wire       third_general_ldo_power_good_in,
  // rail control
  output reg        rail_enable_out,
  output reg  [1:0] rail_power_good_threshold_out
);

  // configuration registers
  reg [7:0] rail_power_good_mask_one;           // one mask bit per rail
  reg [7:0] rail_pin_select_and_mask_two;  // masks, source, threshold
  reg [7:0] rail_edge_delay;               // rise and fall delay codes

  // synchronisers: first stage feeds only the second
  reg [5:0] pin_meta;
  reg [5:0] pin_sync;  // {six, five, four, three, two, one}
  reg [9:0] good_meta;
  reg [9:0] good_sync; // {switch, ldo3, ldo2, load switch, buck_converter_six..1}

  // enable path
  reg        selected_enable;  // output of the pin multiplexer
  wire       delayed_enable;   // after the edge delays
  wire [9:0] good_mask;        // 1 drops a good signal
  wire       goods_ok;         // every kept good is high
  reg        next_rail_enable;

  // field views
  wire [2:0] rail_enable_source;
  wire [2:0] rail_rise_delay;
  wire [2:0] rail_fall_delay;
  wire       mask_first_switch_good;
  wire       mask_third_ldo_good;

  assign rail_enable_source     = rail_pin_select_and_mask_two[`ENABLE_SOURCE_MSB:
                                                               `ENABLE_SOURCE_LSB];
  assign rail_rise_delay        = rail_edge_delay[`RISE_DELAY_MSB:`RISE_DELAY_LSB];
  assign rail_fall_delay        = rail_edge_delay[`FALL_DELAY_MSB:`FALL_DELAY_LSB];
  assign mask_first_switch_good = rail_pin_select_and_mask_two[`MASK_FIRST_SWITCH_BIT];
  assign mask_third_ldo_good    = rail_pin_select_and_mask_two[`MASK_THIRD_LDO_BIT];

  // offset to one-hot register select; writes and reads share one decode
  function [2:0] offset_select;
    input [7:0] offset;
    begin
      case (offset)
        `POWER_GOOD_MASK_ONE_ADDR:   offset_select = 3'h1;
        `PIN_SEL_MASK_TWO_ADDR: offset_select = 3'h2;
        `EDGE_DELAY_ADDR:       offset_select = 3'h4;
        default:                offset_select = 3'h0;  // other blocks own the rest
      endcase
    end
  endfunction

  // one-hot hit: bit 0 mask one, bit 1 pin select, bit 2 edge delay
  wire [2:0] offset_hit;
  assign offset_hit = offset_select(reg_addr_in);

  // register writes; reserved bits are stored but steer nothing
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // all clear: pin one, no delays, every good kept
      rail_power_good_mask_one          <= `POWER_GOOD_MASK_ONE_RST;
      rail_pin_select_and_mask_two <= `PIN_SEL_MASK_TWO_RST;
      rail_edge_delay              <= `EDGE_DELAY_RST;
    end else if (reg_wr_in) begin
      // a miss writes nothing: other offsets belong to other blocks
      if (offset_hit[0]) begin
        rail_power_good_mask_one <= reg_wdata_in;
      end
      if (offset_hit[1]) begin
        // bit 7 is reserved: kept for read back only
        rail_pin_select_and_mask_two <= reg_wdata_in;
      end
      if (offset_hit[2]) begin
        // bits 7:6 are reserved: kept for read back only
        rail_edge_delay <= reg_wdata_in;
      end
    end
  end

  // register reads, answered one cycle after the strobe
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out  <= `UNMAPPED_READ_DATA;
      reg_rvalid_out <= 1'b0;
    end else begin
      // valid mirrors the strobe, so back-to-back reads each get an answer
      reg_rvalid_out <= reg_rd_in;
      // data holds between reads; a same-cycle write shows on the next read
      if (reg_rd_in) begin
        case (offset_hit)
          3'h1:    reg_rdata_out <= rail_power_good_mask_one;
          3'h2:    reg_rdata_out <= rail_pin_select_and_mask_two;
          3'h4:    reg_rdata_out <= rail_edge_delay;
          default: reg_rdata_out <= `UNMAPPED_READ_DATA;  // unmapped reads as zero
        endcase
      end
    end
  end

  // two-stage synchronisers for pins and good signals from analog
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // idle low, so no false enable follows reset
      pin_meta  <= 6'h00;
      pin_sync  <= 6'h00;
      good_meta <= 10'h000;
      good_sync <= 10'h000;
    end else begin
      // first stage may ring; nothing but the second stage reads it
      pin_meta  <= {control_pin_six_in, control_pin_five_in, control_pin_four_in,
                    control_pin_three_in, control_pin_two_in, control_pin_one_in};
      pin_sync  <= pin_meta;
      // goods come from comparators outside the clock domain
      good_meta <= {first_switch_rail_power_good_in, third_general_ldo_power_good_in,
                    second_general_ldo_power_good_in, first_load_switch_power_good_in,
                    buck_power_good_in};
      good_sync <= good_meta;
    end
  end

  // enable source multiplexer
  always @* begin
    // pin_sync order is {six, five, four, three, two, one}
    case (rail_enable_source)
      `SRC_PIN_ONE:        selected_enable = pin_sync[0];
      `SRC_PIN_TWO:        selected_enable = pin_sync[1];
      `SRC_PIN_FIVE:       selected_enable = pin_sync[4];
      `SRC_PIN_FOUR:       selected_enable = pin_sync[3];
      `SRC_PIN_THREE:      selected_enable = pin_sync[2];
      `SRC_PIN_THREE_FOUR: selected_enable = pin_sync[2] & pin_sync[3];
      `SRC_PIN_SIX:        selected_enable = pin_sync[5];
      `SRC_ALWAYS_ON:      selected_enable = 1'b1;
      // unreachable with three select bits; keeps the mux total
      default:             selected_enable = 1'b0;
    endcase
  end

  // rise and fall delays on the selected enable
  // latency: two sync stages, one timer stage and the output flop, so a pin
  // change with delay code zero reaches the rail on the fourth edge
  edge_delay_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_edge_delay (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .level_in     (selected_enable),
    .rise_code_in (rail_rise_delay),
    .fall_code_in (rail_fall_delay),
    .level_out    (delayed_enable)
  );

  // mask bits line up with the synchronised good vector
  assign good_mask = {mask_first_switch_good, mask_third_ldo_good,
                      rail_power_good_mask_one};
  // a masked good counts as high, so it no longer holds the rail back
  assign goods_ok  = &(good_sync | good_mask);

  // the rail latches on once goods agree; only the enable takes it down
  always @* begin
    // hold unless something below moves it
    next_rail_enable = rail_enable_out;
    // enable low wins over goods, so the rail can always be shut off
    if (!delayed_enable) begin
      next_rail_enable = 1'b0;
    end else if (goods_ok) begin
      // a good that drops later does not pull the rail down
      next_rail_enable = 1'b1;
    end
  end

  // rail outputs from flip-flops
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rail_enable_out               <= 1'b0;
      rail_power_good_threshold_out <= 2'h0;
    end else begin
      rail_enable_out               <= next_rail_enable;
      // threshold code only passes through; the comparator sits in the rail
      rail_power_good_threshold_out <= rail_pin_select_and_mask_two[`THRESHOLD_MSB:
                                                                    `THRESHOLD_LSB];
    end
  end

endmodule

// file: rail_enable_props.sv
`timescale 1ns/1ps
// port-level checks of the rail enable block
module rail_enable_props #(
  parameter CYCLES_PER_MS = 125000  // cycles per millisecond
) (
  // clock, reset, register port
  input wire       clk_in, sys_rst_in, reg_wr_in, reg_rd_in, reg_rvalid_out,
  input wire [7:0] reg_addr_in, reg_wdata_in,
  // control pins
  input wire       control_pin_one_in, control_pin_two_in, control_pin_three_in,
  input wire       control_pin_four_in, control_pin_five_in, control_pin_six_in,
  // rail outputs
  input wire       rail_enable_out,
  input wire [1:0] rail_power_good_threshold_out
);
  reg  [7:0]  src_reg, dly;     // shadows of offsets 0x26 and 0x27
  reg  [15:0] hi_run, lo_run;   // cycles the selected enable held high, low
  // pins in source-code order, code 7 a constant one
  wire [7:0]  pin_vec = {1'b1, control_pin_six_in, control_pin_three_in & control_pin_four_in,
    control_pin_three_in, control_pin_four_in, control_pin_five_in, control_pin_two_in,
    control_pin_one_in};
  wire        sel = pin_vec[src_reg[4:2]];
  // delay code to milliseconds
  function integer ms(input [2:0] c);
    ms = (c == 3'h0) ? 0 : (c < 3'h5) ? (1 << c) : (c == 3'h5) ? 24 : (c == 3'h6) ? 32 : 64;
  endfunction
  // shadows and runs; runs wrap only far beyond any test length
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      src_reg <= 8'h00;
      dly     <= 8'h00;
      hi_run  <= 16'h0000;
      lo_run  <= 16'h0000;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'h26) src_reg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h27) dly <= reg_wdata_in;
      hi_run <= sel ? hi_run + 16'h0001 : 16'h0000;
      lo_run <= sel ? 16'h0000 : lo_run + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rd; reg_rd_in |=> reg_rvalid_out; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_nord; !reg_rd_in |=> !reg_rvalid_out; endproperty
  a_nord: assert property (p_nord) else $error("stray read answer");
  property p_thr;
    // register then output flop: the new code is seen two edges on
    reg_wr_in && reg_addr_in == 8'h26 |=> ##1
      rail_power_good_threshold_out == $past(reg_wdata_in[6:5], 2);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not taken");
  property p_thr_hold;
    !(reg_wr_in && reg_addr_in == 8'h26) |=> ##1 $stable(rail_power_good_threshold_out);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold moved");
  property p_latch; (rail_enable_out && sel) [*8] |=> rail_enable_out; endproperty
  a_latch: assert property (p_latch) else $error("rail dropped");
  property p_off; (dly[5:3] == 3'h0 && !sel) [*6] |-> !rail_enable_out; endproperty
  a_off: assert property (p_off) else $error("rail stayed on");
  property p_rise; $rose(rail_enable_out) |-> hi_run >= ms(dly[2:0]) * CYCLES_PER_MS; endproperty
  a_rise: assert property (p_rise) else $error("rise too early");
  property p_fall; $fell(rail_enable_out) |-> lo_run >= ms(dly[5:3]) * CYCLES_PER_MS; endproperty
  a_fall: assert property (p_fall) else $error("fall too early");
  c_pair: cover property (rail_enable_out && src_reg[4:2] == 3'h5);
  c_long: cover property ($fell(rail_enable_out) && dly[5:3] == 3'h7);
  c_rise: cover property ($rose(rail_enable_out));
endmodule

bind shared_rail_enable_logic rail_enable_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (
  .clk_in, .sys_rst_in, .reg_wr_in, .reg_rd_in, .reg_rvalid_out, .reg_addr_in, .reg_wdata_in,
  .control_pin_one_in, .control_pin_two_in, .control_pin_three_in, .control_pin_four_in,
  .control_pin_five_in, .control_pin_six_in, .rail_enable_out, .rail_power_good_threshold_out);

// file: rail_host_model.sv
`timescale 1ns/1ps
// host side: register strobes, control pins, goods of other rails
module rail_host_model (
  input  wire       clk_in,         // clock
  output reg  [7:0] reg_addr_out,   // register offset
  output reg  [7:0] reg_wdata_out,  // write data
  output reg        reg_wr_out,     // one-cycle write strobe
  output reg        reg_rd_out,     // one-cycle read strobe
  input  wire [7:0] reg_rdata_in,   // read answer
  input  wire       reg_rvalid_in,  // answer valid
  output reg  [5:0] pins_out,       // pins six..one
  output reg  [9:0] goods_out       // ldo3, switch rail, ldo2, load switch, bucks 6..1
);
  // all quiet at time zero
  initial {reg_addr_out, reg_wdata_out, reg_wr_out, reg_rd_out, pins_out, goods_out} = 34'h0;
  // one write, strobe up for a single edge
  task wr(input [7:0] a, input [7:0] dat);
    begin
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= dat;
      reg_wr_out <= 1'b1;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
    end
  endtask
  // one read; the answer stands for one cycle after its edge
  task rd(input [7:0] a, output [7:0] dat, output vld);
    begin
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_in);
      reg_rd_out <= 1'b0;
      #1;
      dat = reg_rdata_in;
      vld = reg_rvalid_in;
    end
  endtask
  // new pin and good levels
  task io(input [5:0] p, input [9:0] g);
    begin
      @(posedge clk_in);
      pins_out <= p;
      goods_out <= g;
    end
  endtask
endmodule

// file: shared_rail_enable_logic_tb_top.sv
`timescale 1ns/1ps
module shared_rail_enable_logic_tb_top;
  localparam CPM = 10;  // short millisecond keeps delay runs brief
  // primary pin per source code, pins one..six at bits 0..5
  localparam [47:0] PIN_MAP = {6'h00, 6'h20, 6'h04, 6'h04, 6'h08, 6'h10, 6'h02, 6'h01};
  reg        clk_in, sys_rst_in, v;
  reg  [7:0] d;
  reg  [9:0] m;
  integer    err_count, total_checks, c, i;
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire       reg_wr_in, reg_rd_in, reg_rvalid_out, rail_enable_out;
  wire [1:0] rail_power_good_threshold_out;
  wire [5:0] pins, buck_power_good_in;
  wire [9:0] goods;
  wire       control_pin_one_in, control_pin_two_in, control_pin_three_in, control_pin_four_in;
  wire       control_pin_five_in, control_pin_six_in, second_general_ldo_power_good_in;
  wire       first_load_switch_power_good_in, first_switch_rail_power_good_in;
  wire       third_general_ldo_power_good_in;
  assign {control_pin_six_in, control_pin_five_in, control_pin_four_in, control_pin_three_in,
    control_pin_two_in, control_pin_one_in} = pins;
  assign {third_general_ldo_power_good_in, first_switch_rail_power_good_in,
    second_general_ldo_power_good_in, first_load_switch_power_good_in, buck_power_good_in} = goods;
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  rail_host_model host (.clk_in, .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_rdata_in(reg_rdata_out),
    .reg_rvalid_in(reg_rvalid_out), .pins_out(pins), .goods_out(goods));
  shared_rail_enable_logic #(.CYCLES_PER_MS(CPM)) DUT (.clk_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .control_pin_one_in,
    .control_pin_two_in, .control_pin_three_in, .control_pin_four_in, .control_pin_five_in,
    .control_pin_six_in, .second_general_ldo_power_good_in, .first_load_switch_power_good_in,
    .buck_power_good_in, .first_switch_rail_power_good_in, .third_general_ldo_power_good_in,
    .rail_enable_out, .rail_power_good_threshold_out);
  function integer ms(input [2:0] k);
    ms = (k == 3'h0) ? 0 : (k < 3'h5) ? (1 << k) : (k == 3'h5) ? 24 : (k == 3'h6) ? 32 : 64;
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // read and compare, answer must be flagged valid
  task rchk(input [7:0] a, input [7:0] e);
    begin
      host.rd(a, d, v);
      chk({7'h00, v}, 8'h01);
      chk(d, e);
    end
  endtask
  // rail level after n cycles
  task rail_is(input e, input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1 chk({7'h00, rail_enable_out}, {7'h00, e});
    end
  endtask
  task conclude;
    begin
      if (err_count == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // watchdog well beyond the delay sweep
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    err_count = 0;
    total_checks = 0;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (i = 8'h25; i < 8'h29; i = i + 1) rchk(i[7:0], 8'h00);
    host.wr(8'h25, 8'ha5);
    host.wr(8'h26, 8'hc3);
    host.wr(8'h27, 8'hff);
    rchk(8'h25, 8'ha5);
    rchk(8'h26, 8'hc3);
    rchk(8'h27, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
      host.wr(8'h26, i[7:0] << 5);
      @(posedge clk_in);  // output flop follows the register one edge later
      #1 chk({6'h00, rail_power_good_threshold_out}, i[7:0]);
    end
    host.wr(8'h27, 8'h00);
    host.wr(8'h25, 8'hff);
    // every source code: other pins alone, then the selected ones
    for (c = 0; c < 8; c = c + 1) begin
      host.wr(8'h26, {3'h0, c[2:0], 2'h3});
      host.io(~PIN_MAP[c * 6 +: 6], 10'h3ff);
      rail_is(c == 7, 10);
      host.io(PIN_MAP[c * 6 +: 6] | ((c == 5) ? 6'h08 : 6'h00), 10'h3ff);
      rail_is(1'b1, 10);
      host.io(6'h00, 10'h3ff);
      rail_is(c == 7, 10);
    end
    host.wr(8'h26, 8'h00);
    host.wr(8'h25, 8'h00);
    // each good low in turn blocks the rail until its mask bit is set
    for (i = 0; i < 10; i = i + 1) begin
      m = 10'h001 << i;
      host.io(6'h01, ~m);
      rail_is(1'b0, 12);
      host.wr(8'h25, m[7:0]);
      host.wr(8'h26, {6'h00, m[8], m[9]});
      rail_is(1'b1, 10);
      host.io(6'h00, 10'h3ff);
      host.wr(8'h25, 8'h00);
      host.wr(8'h26, 8'h00);
      rail_is(1'b0, 10);
    end
    // every nonzero delay code on both edges
    for (c = 1; c < 8; c = c + 1) begin
      host.wr(8'h27, {2'h0, c[2:0], c[2:0]});
      host.io(6'h01, 10'h3ff);
      rail_is(1'b0, ms(c) * CPM - 2);
      rail_is(1'b1, 8);
      host.io(6'h00, 10'h3ff);
      rail_is(1'b1, ms(c) * CPM - 2);
      rail_is(1'b0, 8);
    end
    conclude;
  end
endmodule
